/* rtl/phy_mgmt_pkg.sv */
// Constants, field positions and carrier types for the PHY management block
package phy_mgmt_pkg;

  // ==========================================================================
  // Register addresses on the management interface
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_STAT        = 5'h01;

  // ==========================================================================
  // Control register field positions and reset value
  localparam int          CTRL_LOOPBACK   = 14;
  localparam int          CTRL_SPEED_LSB  = 13;
  localparam int          CTRL_AN_ENABLE  = 12;
  localparam int          CTRL_POWER_DOWN = 11;
  localparam int          CTRL_ISOLATE    = 10;
  localparam int          CTRL_AN_RESTART = 9;
  localparam int          CTRL_DUPLEX     = 8;
  localparam int          CTRL_COL_TEST   = 7;
  localparam int          CTRL_SPEED_MSB  = 6;
  localparam logic [15:0] CTRL_RESET      = 16'h1040;

  // ==========================================================================
  // Status register field positions and reset value
  localparam int          STAT_AN_DONE    = 5;
  localparam int          STAT_REM_FAULT  = 4;
  localparam int          STAT_LINK       = 2;
  localparam int          STAT_JABBER     = 1;
  localparam logic [15:0] STAT_RESET      = 16'h7949;
  // Bits that never change: capabilities and fixed abilities
  localparam logic [15:0] STAT_CONST_MASK = 16'hFFC9;

  // ==========================================================================
  // Management frame encoding and lengths
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [4:0]  HDR_BITS        = 5'h0C;
  localparam logic [4:0]  TA_BITS         = 5'h02;
  localparam logic [4:0]  DATA_BITS       = 5'h10;
  localparam logic [4:0]  SKIP_BITS       = 5'h12;

  // ==========================================================================
  // Speed codes
  localparam logic [1:0]  SPEED_10        = 2'h0;
  localparam logic [1:0]  SPEED_100       = 2'h1;
  localparam logic [1:0]  SPEED_1000      = 2'h2;
  localparam logic [1:0]  SPEED_RESERVED  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HEADER,
    ST_TURN,
    ST_DATA_RD,
    ST_DATA_WR,
    ST_SKIP
  } mdio_state_t;

  typedef struct packed {
    logic       tx_en;
    logic       tx_er;
    logic [7:0] txd;
  } mac_tx_t;

  typedef struct packed {
    logic       rx_dv;
    logic       rx_er;
    logic [7:0] rxd;
    logic       crs;
    logic       col;
  } mac_rx_t;

endpackage : phy_mgmt_pkg

/* rtl/phy_mgmt_control_status.sv */
// Management control and status registers of a 10/100/1000 PHY
`timescale 1ns/1ps
`default_nettype none

module phy_mgmt_control_status (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic [4:0]            i_phy_addr,
  input  wire logic                  i_mdc,
  input  wire logic                  i_mdio,
  output logic                       o_mdio,
  output logic                       o_mdio_oe,
  input  wire logic                  i_an_started,
  input  wire logic                  i_an_done,
  input  wire logic [1:0]            i_an_speed,
  input  wire logic                  i_an_full_duplex,
  input  wire logic                  i_link_up,
  input  wire logic                  i_remote_fault,
  input  wire logic                  i_jabber,
  input  wire phy_mgmt_pkg::mac_tx_t i_mac_tx,
  output phy_mgmt_pkg::mac_rx_t      o_mac_rx,
  output logic                       o_mac_rx_oe,
  input  wire phy_mgmt_pkg::mac_rx_t i_line_rx,
  output phy_mgmt_pkg::mac_tx_t      o_line_tx,
  output logic                       o_an_enable,
  output logic                       o_an_restart,
  output logic                       o_power_down,
  output logic                       o_link_drop,
  output logic                       o_loopback,
  output logic [1:0]                 o_speed,
  output logic                       o_full_duplex
);

  // ==========================================================================
  // State
  typedef struct packed {
    phy_mgmt_pkg::mdio_state_t fsm;
    logic [4:0]                cnt;
    logic [15:0]               shift;
    logic [1:0]                op;
    logic                      mine;
    logic [4:0]                regad;
    logic                      mdc_q;
    logic                      mdio_out;
    logic                      mdio_oe;
    logic                      loopback;
    logic                      speed_lsb;
    logic                      an_enable;
    logic                      power_down;
    logic                      isolate;
    logic                      an_restart;
    logic                      duplex;
    logic                      col_test;
    logic                      speed_msb;
    logic                      held_fault;
    logic                      held_link;
    logic                      held_jabber;
    logic                      link_drop;
    logic [1:0]                speed;
    logic                      full_duplex;
    phy_mgmt_pkg::mac_rx_t     mac_rx;
    phy_mgmt_pkg::mac_tx_t     line_tx;
  } state_t;

  state_t s;
  state_t next_s;

  logic        mdc_rise;
  logic [11:0] hdr;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  logic        rd_clear;
  logic        mac_live;
  logic [1:0]  forced_code;
  logic [15:0] wr_word;

  // ==========================================================================
  // Register views
  always_comb begin
    ctrl_view = '0;
    ctrl_view[phy_mgmt_pkg::CTRL_LOOPBACK]   = s.loopback;
    ctrl_view[phy_mgmt_pkg::CTRL_SPEED_LSB]  = s.speed_lsb;
    ctrl_view[phy_mgmt_pkg::CTRL_AN_ENABLE]  = s.an_enable;
    ctrl_view[phy_mgmt_pkg::CTRL_POWER_DOWN] = s.power_down;
    ctrl_view[phy_mgmt_pkg::CTRL_ISOLATE]    = s.isolate;
    ctrl_view[phy_mgmt_pkg::CTRL_AN_RESTART] = s.an_restart;
    ctrl_view[phy_mgmt_pkg::CTRL_DUPLEX]     = s.duplex;
    ctrl_view[phy_mgmt_pkg::CTRL_COL_TEST]   = s.col_test;
    ctrl_view[phy_mgmt_pkg::CTRL_SPEED_MSB]  = s.speed_msb;
    // Capability bits are constants from reset value
    stat_view = phy_mgmt_pkg::STAT_RESET &
                phy_mgmt_pkg::STAT_CONST_MASK;
    stat_view[phy_mgmt_pkg::STAT_AN_DONE]   = i_an_done;
    stat_view[phy_mgmt_pkg::STAT_REM_FAULT] = s.held_fault;
    stat_view[phy_mgmt_pkg::STAT_LINK]      = s.held_link;
    stat_view[phy_mgmt_pkg::STAT_JABBER]    = s.held_jabber;
  end

  assign mdc_rise    = i_mdc & ~s.mdc_q;
  assign hdr         = {s.shift[10:0], i_mdio};
  assign mac_live    = ~s.power_down & ~s.isolate;
  assign forced_code = {s.speed_msb, s.speed_lsb};
  assign wr_word     = {s.shift[14:0], i_mdio};

  // ==========================================================================
  // Next state
  always_comb begin
    next_s       = s;
    next_s.mdc_q = i_mdc;
    rd_clear     = 1'b0;

    // Management frame receiver and responder
    if (mdc_rise) begin
      case (s.fsm)
        phy_mgmt_pkg::ST_IDLE: begin
          // Preamble is optional: any 0 opens a start field
          next_s.mdio_oe = 1'b0;
          if (!i_mdio) begin
            next_s.fsm = phy_mgmt_pkg::ST_START;
          end
        end
        phy_mgmt_pkg::ST_START: begin
          next_s.cnt = '0;
          next_s.fsm = i_mdio ? phy_mgmt_pkg::ST_HEADER
                              : phy_mgmt_pkg::ST_IDLE;
        end
        phy_mgmt_pkg::ST_HEADER: begin
          next_s.shift = {s.shift[14:0], i_mdio};
          next_s.cnt   = s.cnt + 5'h01;
          if (s.cnt == phy_mgmt_pkg::HDR_BITS - 5'h01) begin
            next_s.op    = hdr[11:10];
            next_s.mine  = (hdr[9:5] == i_phy_addr);
            next_s.regad = hdr[4:0];
            next_s.cnt   = '0;
            if (hdr[11:10] == phy_mgmt_pkg::OP_READ &&
                hdr[9:5] == i_phy_addr) begin
              next_s.fsm = phy_mgmt_pkg::ST_TURN;
              if (hdr[4:0] == phy_mgmt_pkg::REG_CTRL) begin
                next_s.shift = ctrl_view;
              end else if (hdr[4:0] == phy_mgmt_pkg::REG_STAT) begin
                next_s.shift = stat_view;
                rd_clear     = 1'b1;
              end else begin
                next_s.shift = '0;
              end
            end else if (hdr[11:10] == phy_mgmt_pkg::OP_WRITE) begin
              next_s.fsm = phy_mgmt_pkg::ST_TURN;
            end else begin
              next_s.fsm = phy_mgmt_pkg::ST_SKIP;
            end
          end
        end
        phy_mgmt_pkg::ST_TURN: begin
          next_s.cnt = s.cnt + 5'h01;
          if (s.op == phy_mgmt_pkg::OP_READ) begin
            if (s.cnt == '0) begin
              next_s.mdio_oe  = 1'b1;
              next_s.mdio_out = 1'b0;
            end else begin
              next_s.mdio_out = s.shift[15];
              next_s.shift    = {s.shift[14:0], 1'b0};
              next_s.cnt      = '0;
              next_s.fsm      = phy_mgmt_pkg::ST_DATA_RD;
            end
          end else if (s.cnt == phy_mgmt_pkg::TA_BITS - 5'h01) begin
            next_s.cnt = '0;
            next_s.fsm = phy_mgmt_pkg::ST_DATA_WR;
          end
        end
        phy_mgmt_pkg::ST_DATA_RD: begin
          next_s.cnt = s.cnt + 5'h01;
          if (s.cnt == phy_mgmt_pkg::DATA_BITS - 5'h01) begin
            next_s.mdio_oe = 1'b0;
            next_s.fsm     = phy_mgmt_pkg::ST_IDLE;
          end else begin
            next_s.mdio_out = s.shift[15];
            next_s.shift    = {s.shift[14:0], 1'b0};
          end
        end
        phy_mgmt_pkg::ST_DATA_WR: begin
          next_s.shift = {s.shift[14:0], i_mdio};
          next_s.cnt   = s.cnt + 5'h01;
          if (s.cnt == phy_mgmt_pkg::DATA_BITS - 5'h01) begin
            next_s.fsm = phy_mgmt_pkg::ST_IDLE;
            // Status writes fall through untouched
            if (s.mine && s.regad == phy_mgmt_pkg::REG_CTRL) begin
              next_s.loopback   = wr_word[phy_mgmt_pkg::CTRL_LOOPBACK];
              next_s.speed_lsb  = wr_word[phy_mgmt_pkg::CTRL_SPEED_LSB];
              next_s.an_enable  = wr_word[phy_mgmt_pkg::CTRL_AN_ENABLE];
              next_s.power_down = wr_word[phy_mgmt_pkg::CTRL_POWER_DOWN];
              next_s.isolate    = wr_word[phy_mgmt_pkg::CTRL_ISOLATE];
              next_s.duplex     = wr_word[phy_mgmt_pkg::CTRL_DUPLEX];
              next_s.col_test   = wr_word[phy_mgmt_pkg::CTRL_COL_TEST];
              next_s.speed_msb  = wr_word[phy_mgmt_pkg::CTRL_SPEED_MSB];
              // Writing 0 keeps a pending restart set unless negotiation is written off too
              if (wr_word[phy_mgmt_pkg::CTRL_AN_RESTART] &&
                  wr_word[phy_mgmt_pkg::CTRL_AN_ENABLE]) begin
                next_s.an_restart = 1'b1;
              end
            end
          end
        end
        phy_mgmt_pkg::ST_SKIP: begin
          // Foreign frames are counted out so data is never taken as start
          next_s.cnt = s.cnt + 5'h01;
          if (s.cnt == phy_mgmt_pkg::SKIP_BITS - 5'h01) begin
            next_s.fsm = phy_mgmt_pkg::ST_IDLE;
          end
        end
        default: begin
          next_s.fsm     = phy_mgmt_pkg::ST_IDLE;
          next_s.mdio_oe = 1'b0;
        end
      endcase
    end

    // Self-clear once negotiation has begun; a same-cycle write wins
    if (i_an_started && !(next_s.an_restart && !s.an_restart)) begin
      next_s.an_restart = 1'b0;
    end
    if (!next_s.an_enable) begin
      next_s.an_restart = 1'b0;
    end

    // Latched status: the event wins over the clearing read
    next_s.held_fault  = i_remote_fault |
                         (s.held_fault & ~rd_clear);
    next_s.held_jabber = i_jabber | (s.held_jabber & ~rd_clear);
    next_s.held_link   = i_link_up & (s.held_link | rd_clear);

    // Operating mode
    next_s.link_drop = next_s.power_down & ~s.power_down;
    if (s.an_enable) begin
      if (i_an_speed != phy_mgmt_pkg::SPEED_RESERVED) begin
        next_s.speed = i_an_speed;
      end
    end else if (forced_code != phy_mgmt_pkg::SPEED_RESERVED) begin
      next_s.speed = forced_code;
    end
    if (s.loopback) begin
      next_s.full_duplex = 1'b1;
    end else if (s.an_enable) begin
      next_s.full_duplex = i_an_full_duplex;
    end else begin
      next_s.full_duplex = s.duplex;
    end

    // MAC-side data paths, one flop of latency each way
    next_s.line_tx = mac_live ? i_mac_tx : '0;
    next_s.mac_rx  = '0;
    if (!s.power_down) begin
      if (s.loopback) begin
        next_s.mac_rx.rx_dv = i_mac_tx.tx_en;
        next_s.mac_rx.rx_er = i_mac_tx.tx_er;
        next_s.mac_rx.rxd   = i_mac_tx.txd;
        next_s.mac_rx.crs   = i_mac_tx.tx_en;
      end else begin
        next_s.mac_rx     = i_line_rx;
        next_s.mac_rx.col = i_line_rx.col;
      end
      if (s.col_test) begin
        next_s.mac_rx.col = i_mac_tx.tx_en;
      end
      if (s.isolate) begin
        next_s.mac_rx = '0;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s            <= '0;
      s.fsm        <= phy_mgmt_pkg::ST_IDLE;
      s.loopback   <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_LOOPBACK];
      s.speed_lsb  <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_SPEED_LSB];
      s.an_enable  <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_AN_ENABLE];
      s.power_down <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_POWER_DOWN];
      s.isolate    <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_ISOLATE];
      s.duplex     <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_DUPLEX];
      s.col_test   <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_COL_TEST];
      s.speed_msb  <= phy_mgmt_pkg::CTRL_RESET[phy_mgmt_pkg::CTRL_SPEED_MSB];
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_mdio        = s.mdio_out;
  assign o_mdio_oe     = s.mdio_oe;
  assign o_mac_rx      = s.mac_rx;
  assign o_mac_rx_oe   = ~s.isolate;
  assign o_line_tx     = s.line_tx;
  assign o_an_enable   = s.an_enable;
  assign o_an_restart  = s.an_restart;
  assign o_power_down  = s.power_down;
  assign o_link_drop   = s.link_drop;
  assign o_loopback    = s.loopback;
  assign o_speed       = s.speed;
  assign o_full_duplex = s.full_duplex;

endmodule : phy_mgmt_control_status

`default_nettype wire

/* testbench/mdio_master.sv */
// Station management master model that drives management frames
`timescale 1ns/1ps
`default_nettype none
module mdio_master (
  input  wire logic i_clk,
  input  wire logic i_mdio_out,
  input  wire logic i_mdio_oe,
  output logic      o_mdc,
  output logic      o_mdio
);
  logic wire_lvl;
  // Pull-up on the shared line: a released line reads high
  assign wire_lvl = i_mdio_oe ? i_mdio_out : 1'b1;
  initial begin
    o_mdc  = 1'b0;
    o_mdio = 1'b1;
  end
  // ==========================================================================
  // One frame, MSB first; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'h1, op, phy, rg, 2'h2, wd};
    if (op == phy_mgmt_pkg::OP_READ) bits[17:0] = 18'h3FFFF;
    for (int i = 0; i < 32; i++) begin
      @(posedge i_clk);
      o_mdc  <= 1'b0;
      o_mdio <= bits[31-i];
      repeat (2) @(posedge i_clk);
      if (i >= 16) rd[31-i] = wire_lvl;
      o_mdc <= 1'b1;
      @(posedge i_clk);
    end
    @(posedge i_clk);
    o_mdc  <= 1'b0;
    o_mdio <= 1'b1;
  endtask : frame
endmodule : mdio_master
`default_nettype wire

/* testbench/phy_mgmt_assertions.sv */
// Port-level checker for the management control and status block
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_checker (
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire phy_mgmt_pkg::mac_tx_t i_mac_tx,
  input wire logic [1:0]            i_an_speed,
  input wire logic                  i_an_full_duplex,
  input wire logic                  i_an_started,
  input wire phy_mgmt_pkg::mac_tx_t o_line_tx,
  input wire phy_mgmt_pkg::mac_rx_t o_mac_rx,
  input wire logic                  o_mac_rx_oe,
  input wire logic                  o_power_down,
  input wire logic                  o_link_drop,
  input wire logic                  o_loopback,
  input wire logic                  o_an_enable,
  input wire logic                  o_an_restart,
  input wire logic [1:0]            o_speed,
  input wire logic                  o_full_duplex
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================================
  // Two- and three-cycle guards avoid judging the edge where a mode changes
  a_tx_pass: assert property (o_mac_rx_oe && !o_power_down &&
    $past(i_resetn) && $past(o_mac_rx_oe) && !$past(o_power_down)
    |-> o_line_tx == $past(i_mac_tx))
    else $error("line transmit does not follow MAC input");
  a_iso_zero: assert property (!o_mac_rx_oe && !$past(o_mac_rx_oe)
    |-> o_line_tx == '0) else $error("isolate passes MAC input");
  a_pwrdn_quiet: assert property (o_power_down && $past(o_power_down)
    |-> o_mac_rx == '0 && o_line_tx == '0) else $error("data in power-down");
  a_link_drop: assert property ($rose(o_power_down)
    |-> ##[0:1] o_link_drop) else $error("no link drop on power-down");
  a_drop_pulse: assert property (o_link_drop |=> !o_link_drop)
    else $error("link drop longer than one cycle");
  a_loop_duplex: assert property (o_loopback [*3] |-> o_full_duplex)
    else $error("loop-back not full duplex");
  a_an_follow: assert property ($past(o_an_enable) &&
    !$past(o_loopback) && $past(i_an_speed) != 2'h3 |-> o_speed ==
    $past(i_an_speed) && o_full_duplex == $past(i_an_full_duplex))
    else $error("negotiated speed or duplex not applied");
  a_restart_clr: assert property (o_an_restart && i_an_started
    |=> !o_an_restart) else $error("restart not cleared");
  a_restart_an: assert property ($rose(o_an_restart) |-> o_an_enable)
    else $error("restart set with negotiation off");
  a_speed_legal: assert property (o_speed != 2'h3)
    else $error("reserved speed code applied");
  c_power_down: cover property ($rose(o_power_down));
  c_isolate: cover property ($fell(o_mac_rx_oe));
  c_restart: cover property ($rose(o_an_restart));
endmodule : phy_mgmt_checker
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the management control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [4:0] PHY = 5'h05;
  logic                  i_clk = 1'b0;
  logic                  i_resetn = 1'b0;
  logic [4:0]            i_phy_addr = PHY;
  logic                  i_mdc, i_mdio, o_mdio, o_mdio_oe;
  logic                  i_an_started = 1'b0, i_an_done = 1'b0;
  logic [1:0]            i_an_speed = 2'h0, o_speed, es = 2'h0;
  logic                  i_an_full_duplex = 1'b0, i_link_up = 1'b1;
  logic                  i_remote_fault = 1'b0, i_jabber = 1'b0;
  phy_mgmt_pkg::mac_tx_t i_mac_tx = '0, o_line_tx, p_tx = '0;
  phy_mgmt_pkg::mac_rx_t i_line_rx = '0, o_mac_rx, p_rx = '0;
  logic                  o_mac_rx_oe, o_an_enable, o_an_restart;
  logic                  o_power_down, o_link_drop, o_loopback, o_full_duplex;
  logic [15:0]           ctrl = 16'h1040;
  logic [15:0]           modes [7] = '{16'h4000, 16'h0080, 16'h4080,
                                       16'h003F, 16'h0400, 16'h0800, 16'h0000};
  logic                  rf_l = 1'b0, jd_l = 1'b0, ls_l = 1'b0;
  logic [31:0]           seed = 32'h55;
  int                    num_errors = 0, n_compared = 0;

  phy_mgmt_control_status i_phy_mgmt_control_status (.i_clk, .i_resetn,
    .i_phy_addr, .i_mdc, .i_mdio, .o_mdio, .o_mdio_oe, .i_an_started,
    .i_an_done, .i_an_speed, .i_an_full_duplex, .i_link_up, .i_remote_fault,
    .i_jabber, .i_mac_tx, .o_mac_rx, .o_mac_rx_oe, .i_line_rx, .o_line_tx,
    .o_an_enable, .o_an_restart, .o_power_down, .o_link_drop, .o_loopback,
    .o_speed, .o_full_duplex);
  mdio_master i_mdio_master (.i_clk, .i_mdio_out(o_mdio),
    .i_mdio_oe(o_mdio_oe), .o_mdc(i_mdc), .o_mdio(i_mdio));

  initial forever #25 i_clk = ~i_clk;
  // ==========================================================================
  // Random data on both data paths every cycle
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xorshift
  always @(posedge i_clk) begin
    seed = xorshift(seed);
    p_tx      <= i_mac_tx;
    p_rx      <= i_line_rx;
    i_mac_tx  <= phy_mgmt_pkg::mac_tx_t'(seed[9:0]);
    i_line_rx <= phy_mgmt_pkg::mac_rx_t'(seed[27:16]);
  end
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic rd(input logic [4:0] phy, rg, input logic [15:0] exp);
    logic [15:0] v;
    i_mdio_master.frame(phy_mgmt_pkg::OP_READ, phy, rg, 16'h0, v);
    check(v, exp);
  endtask : rd
  task automatic rd_stat();
    rd(PHY, 5'h01, 16'h7949 | {10'h0, i_an_done, rf_l, 1'b0, ls_l, jd_l,
       1'b0});
    rf_l = i_remote_fault;
    jd_l = i_jabber;
    ls_l = i_link_up;
  endtask : rd_stat
  // Restart only takes hold with negotiation on in the same value
  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] v;
    i_mdio_master.frame(phy_mgmt_pkg::OP_WRITE, PHY, rg, d, v);
    if (rg == 5'h00) ctrl = (d & 16'h7DC0) |
      {6'h0, d[12] & (d[9] | ctrl[9]), 9'h0};
    repeat (3) @(posedge i_clk);
    #1;
    if (!ctrl[12]) begin
      if ({ctrl[6], ctrl[13]} != 2'h3) es = {ctrl[6], ctrl[13]};
      check(16'(o_speed), 16'(es));
      check(16'(o_full_duplex), 16'(ctrl[14] | ctrl[8]));
    end
    check(16'({o_loopback, o_an_enable, o_power_down}),
          16'({ctrl[14], ctrl[12], ctrl[11]}));
    rd(PHY, 5'h00, ctrl);
  endtask : wr
  task automatic watch(input int n);
    phy_mgmt_pkg::mac_rx_t r;
    repeat (n) begin
      @(negedge i_clk);
      r = ctrl[14] ? {p_tx.tx_en, p_tx.tx_er, p_tx.txd, p_tx.tx_en, 1'b0}
                   : p_rx;
      if (ctrl[7]) r.col = p_tx.tx_en;
      if (ctrl[11] || ctrl[10]) r = '0;
      check(16'(o_mac_rx), 16'(r));
      check(16'(o_line_tx),
            (ctrl[11] | ctrl[10]) ? 16'h0 : 16'(p_tx));
      check(16'(o_mac_rx_oe), 16'(!ctrl[10]));
    end
  endtask : watch
  // ==========================================================================
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rd(PHY, 5'h00, 16'h1040);
    rd_stat();
    rd_stat();
    rd(PHY, 5'h02, 16'h0000);
    rd(5'h06, 5'h01, 16'hFFFF);
    wr(5'h00, 16'h1140);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      i_an_speed       <= 2'(s);
      i_an_full_duplex <= s[0];
      repeat (3) @(posedge i_clk);
      #1;
      check(16'(o_speed), (s == 3) ? 16'h2 : 16'(s));
      check(16'(o_full_duplex), 16'(s[0]));
    end
    for (int c = 0; c < 8; c++)
      wr(5'h00, {2'h0, c[1], 4'h0, c[0], 1'b0, c[2], 6'h0});
    watch(20);
    foreach (modes[m]) begin
      wr(5'h00, modes[m]);
      watch(20);
    end
    wr(5'h00, 16'h1200);
    check(16'(o_an_restart), 16'h1);
    @(posedge i_clk) i_an_started <= 1'b1;
    @(posedge i_clk) i_an_started <= 1'b0;
    ctrl[9] = 1'b0;
    repeat (2) @(posedge i_clk);
    rd(PHY, 5'h00, ctrl);
    wr(5'h00, 16'h0200);
    check(16'(o_an_restart), 16'h0);
    wr(5'h01, 16'h0000);
    rd_stat();
    // Unknown op code and foreign address both leave control untouched
    i_mdio_master.frame(2'h3, PHY, 5'h00, 16'h0800, ctrl);
    i_mdio_master.frame(phy_mgmt_pkg::OP_WRITE, 5'h06, 5'h00, 16'h0800, ctrl);
    rd(PHY, 5'h00, 16'h0000);
    ctrl = 16'h0000;
    @(posedge i_clk);
    {i_remote_fault, i_jabber, i_link_up, i_an_done} <= 4'hD;
    {rf_l, jd_l, ls_l} = 3'h6;
    @(posedge i_clk) {i_remote_fault, i_jabber, i_link_up} <= 3'h1;
    rd_stat();
    rd_stat();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    num_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire

bind phy_mgmt_control_status phy_mgmt_checker i_phy_mgmt_checker (.i_clk,
  .i_resetn, .i_mac_tx, .i_an_speed, .i_an_full_duplex, .i_an_started,
  .o_line_tx, .o_mac_rx, .o_mac_rx_oe, .o_power_down, .o_link_drop,
  .o_loopback, .o_an_enable, .o_an_restart, .o_speed, .o_full_duplex);
